//--- hw/ext_irq_pkg.sv
// Constants and types for the external interrupt monitor and lockout block
package ext_irq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned CHANNELS_DEF = 16;
  localparam int unsigned CHANNELS_MAX = 31;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN_CLEAR = 8'h04;
  localparam logic [7:0] OFS_WATCH = 8'h08;
  localparam logic [7:0] OFS_REQUEST = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // ****************************************
  // Control field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_GLOBAL_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam int unsigned CTRL_WIDTH = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] MASK_RESET = 32'h0;
  localparam logic [31:0] STATUS_RESET = 32'h0;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // Data phase of the bus slave
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_type;

  // Per-channel steering from the control logic
  typedef struct packed {
    logic lockout;
    logic clear_all;
    logic clear_chan;
  } watch_ctrl_type;

endpackage

//--- hw/channel_watch.sv
// One channel of external request detection with its watch flip-flop
`timescale 1ns/1ps
module channel_watch (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Request and steering
  input wire logic ext_irq_request_in,
  input wire ext_irq_pkg::watch_ctrl_type ctrl_in,
  // Detection and watch state
  output logic detect_out,
  output logic ext_irq_watch_ff_out
);
  import ext_irq_pkg::*;

  logic watch_q;

  // ****************************************
  // Detection
  // ****************************************
  // Blocked while watched or locked out
  assign detect_out = ce_in & ext_irq_request_in & ~watch_q & ~ctrl_in.lockout;

  // ****************************************
  // Watch flip-flop
  // ****************************************
  // Set on detection wins over a clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watch_q <= 1'b0;
    end else if (ce_in) begin
      if (detect_out) begin
        watch_q <= 1'b1;
      end else if (ctrl_in.clear_all || ctrl_in.clear_chan) begin
        watch_q <= 1'b0;
      end
    end
  end

  assign ext_irq_watch_ff_out = watch_q;

  // ****************************************
  // Checks
  // ****************************************
  chk_watch_blocks_detect: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    watch_q |-> !detect_out) else $error("request detected while watched");
  chk_lockout_blocks_all: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ctrl_in.lockout |-> !detect_out ##1 !$rose(watch_q)) else $error("lockout did not block");
  chk_watch_held: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    watch_q && ce_in && !ctrl_in.clear_all && !ctrl_in.clear_chan |=> watch_q) else $error("watch dropped early");
  chk_chan_clear_works: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ce_in && ctrl_in.clear_chan && !detect_out |=> !watch_q) else $error("channel clear missed");
  chk_watch_from_request: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(watch_q) |-> $past(ext_irq_request_in) && !$past(ctrl_in.lockout)) else $error("watch set without request");

endmodule // channel_watch

//--- hw/sync_one_shot.sv
// One-shot stage for the external sync input
`timescale 1ns/1ps
module sync_one_shot (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Sync input and panel switch
  input wire logic ext_sync_in,
  input wire logic ext_sync_disable_switch_in,
  // One pulse per occurrence
  output logic pulse_out
);
  import ext_irq_pkg::*;

  logic sync_one_shot_ff_q;

  // Remembers the level seen last cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_one_shot_ff_q <= 1'b0;
    end else if (ce_in) begin
      sync_one_shot_ff_q <= ext_sync_in;
    end
  end

  // Leading edge only, dropped when disconnected
  assign pulse_out = ce_in & ext_sync_in & ~sync_one_shot_ff_q & ~ext_sync_disable_switch_in;

  chk_one_shot_once: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    pulse_out |=> !pulse_out) else $error("sync pulse repeated");
  chk_sync_disabled: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ext_sync_disable_switch_in |-> !pulse_out) else $error("sync pulse while disconnected");

endmodule // sync_one_shot

//--- hw/ext_irq_monitor.sv
// External interrupt monitor and lockout block with AHB-Lite registers
// Operation
// - clearing the global lockout sends a clear pulse to every watch flip-flop
// - a per-channel clear select pulse clears that channel's watch flip-flop
// - while a watch flip-flop is set, requests on its channel go undetected
// - the external lockout blocks watching and request detection on all channels
// - external sync passes a one-shot so each occurrence sets its flag once
// - the disconnect switch suppresses the external sync interrupt entirely
// - external sync is presented for service the same way as a channel request
// - watch handling on a channel starts only from a request on that channel
// - watch flip-flops stay set until software clears the global lockout or selects that channel's clear
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ext_irq_monitor #(
  parameter int unsigned CHANNELS = ext_irq_pkg::CHANNELS_DEF
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [1:0] hresp_out,
  output logic [31:0] hrdata_out,
  // External requests and sync
  input wire logic [CHANNELS-1:0] ext_irq_request_in,
  input wire logic ext_sync_in,
  input wire logic ext_sync_disable_switch_in,
  // State and interrupt
  output logic [CHANNELS-1:0] ext_irq_watch_ff_out,
  output logic [CHANNELS:0] service_req_out,
  output logic irq_out
);
  import ext_irq_pkg::*;

  localparam int unsigned NB = CHANNELS + 1;

  // ****************************************
  // Elaboration check
  // ****************************************
  if (CHANNELS < 1 || CHANNELS > CHANNELS_MAX) begin : g_bad_channels
    $error("CHANNELS must lie between 1 and 31");
  end

  // ****************************************
  // Declarations
  // ****************************************
  // Bus slave state
  phase_type phase_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  // Lockout and clear control
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic clear_all_q;
  logic [CHANNELS-1:0] channel_clear_select_ff_q;
  // Interrupt state
  logic [NB-1:0] mask_q;
  logic [NB-1:0] status_q;
  logic [NB-1:0] status_clr;
  logic [NB-1:0] status_d;
  // Channel and sync results
  logic [CHANNELS-1:0] detect;
  logic [CHANNELS-1:0] watch;
  logic sync_pulse;
  logic [NB-1:0] events;
  // Bus decode
  logic addr_phase;
  logic wr_go;
  logic wr_ctrl;
  logic wr_chan_clear;
  logic wr_status;
  logic wr_mask;
  // Lockout levels and read word
  logic global_irq_lockout_ff;
  logic external_irq_lockout_ff;
  logic [31:0] read_word;

  // ****************************************
  // Bus slave
  // ****************************************
  // Register map, one word each:
  //   CTRL       global lockout bit 0, external lockout bit 1
  //   CHAN_CLEAR write ones to drop watch flip-flops, reads zero
  //   WATCH      watch flip-flops, read only
  //   REQUEST    raw request lines, read only
  //   STATUS     sticky events, sync on the top bit, write one to clear
  //   MASK       interrupt enables, same layout as STATUS

  // Address phase accepted on a valid transfer
  assign addr_phase = ce_in & hsel_in & hready_in & htrans_in[1];

  // Zero wait states; a frozen block stalls the bus
  assign hreadyout_out = ce_in;
  assign hresp_out = HRESP_OKAY;
  assign hrdata_out = hrdata_q;

  // Data phase tracking
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= PH_IDLE;
      addr_q <= 8'h00;
    end else if (ce_in) begin
      if (hready_in) begin
        if (addr_phase) begin
          phase_q <= hwrite_in ? PH_WRITE : PH_READ;
          addr_q <= {haddr_in[7:2], 2'b00};
        end else begin
          phase_q <= PH_IDLE;
        end
      end
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  // Write strobes during a write data phase
  always_comb begin
    wr_go = 1'b0;
    case (phase_q)
      PH_WRITE: wr_go = ce_in;
      PH_READ: wr_go = 1'b0;
      PH_IDLE: wr_go = 1'b0;
      default: wr_go = 1'b0;
    endcase
  end

  assign wr_ctrl = wr_go & (addr_q == OFS_CTRL);
  assign wr_chan_clear = wr_go & (addr_q == OFS_CHAN_CLEAR);
  assign wr_status = wr_go & (addr_q == OFS_STATUS);
  assign wr_mask = wr_go & (addr_q == OFS_MASK);

  // ****************************************
  // Read path
  // ****************************************
  // Read mux; unmapped offsets read zero
  always_comb begin
    read_word = 32'h0;
    case ({haddr_in[7:2], 2'b00})
      OFS_CTRL: read_word = 32'(ctrl_q);
      OFS_WATCH: read_word = 32'(watch);
      OFS_REQUEST: read_word = 32'(ext_irq_request_in);
      OFS_STATUS: read_word = 32'(status_q);
      OFS_MASK: read_word = 32'(mask_q);
      default: read_word = 32'h0;
    endcase
  end

  // Read data captured in the address phase
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_q <= 32'h0;
    end else if (addr_phase && !hwrite_in) begin
      hrdata_q <= read_word;
    end
  end

  // ****************************************
  // Lockout control
  // ****************************************
  assign global_irq_lockout_ff = ctrl_q[CTRL_GLOBAL_BIT];
  assign external_irq_lockout_ff = ctrl_q[CTRL_EXT_BIT];

  // Control register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata_in[CTRL_WIDTH-1:0];
    end
  end

  // Clear pulse when the global lockout falls
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clear_all_q <= 1'b0;
    end else if (ce_in) begin
      clear_all_q <= wr_ctrl & global_irq_lockout_ff & ~hwdata_in[CTRL_GLOBAL_BIT];
    end
  end

  // Per-channel clear select, one cycle per written one
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      channel_clear_select_ff_q <= '0;
    end else if (ce_in) begin
      channel_clear_select_ff_q <= wr_chan_clear ? hwdata_in[CHANNELS-1:0] : '0;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    watch_ctrl_type wctrl;
    assign wctrl = '{
      lockout: external_irq_lockout_ff,
      clear_all: clear_all_q,
      clear_chan: channel_clear_select_ff_q[i]
    };
    channel_watch u_watch (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .ext_irq_request_in(ext_irq_request_in[i]),
      .ctrl_in(wctrl),
      .detect_out(detect[i]),
      .ext_irq_watch_ff_out(watch[i])
    );
  end

  assign ext_irq_watch_ff_out = watch;

  // ****************************************
  // External sync
  // ****************************************
  sync_one_shot u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .ext_sync_in(ext_sync_in),
    .ext_sync_disable_switch_in(ext_sync_disable_switch_in),
    .pulse_out(sync_pulse)
  );

  // Sync joins the channel requests on one path
  assign events = {sync_pulse, detect};

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Write-one-to-clear bits from the bus
  assign status_clr = wr_status ? hwdata_in[NB-1:0] : '0;
  // New events win over a clear in the same cycle
  assign status_d = (status_q & ~status_clr) | events;

  // Sticky status register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= STATUS_RESET[NB-1:0];
    end else if (ce_in) begin
      status_q <= status_d;
    end
  end

  // Mask register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_q <= MASK_RESET[NB-1:0];
    end else if (wr_mask) begin
      mask_q <= hwdata_in[NB-1:0];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Pending requests and the single level interrupt
  assign service_req_out = status_q;
  assign irq_out = |(status_q & mask_q);

  // ****************************************
  // Checks
  // ****************************************
  // Software drops the global lockout
  sequence s_global_drop;
    wr_ctrl && global_irq_lockout_ff && !hwdata_in[CTRL_GLOBAL_BIT];
  endsequence

  // Clear pulse of exactly one cycle
  sequence s_clear_once;
    clear_all_q ##1 !clear_all_q;
  endsequence

  chk_global_clear_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_global_drop |=> s_clear_once) else $error("no clear pulse after lockout release");
  chk_clear_only_on_drop: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(clear_all_q) |-> $past(wr_ctrl) && $past(global_irq_lockout_ff)) else $error("clear pulse without release");
  chk_global_clears_watch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    clear_all_q && ce_in |=> (watch & ~$past(detect)) == '0) else $error("watch survived global clear");
  chk_chan_select_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_chan_clear |=> channel_clear_select_ff_q == $past(hwdata_in[CHANNELS-1:0])) else $error("clear select wrong");
  chk_detect_gated: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (detect & watch) == '0) else $error("detection on a watched channel");
  chk_ext_lockout: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    external_irq_lockout_ff |-> detect == '0) else $error("detection under external lockout");
  chk_sync_status: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sync_pulse |=> status_q[CHANNELS] && service_req_out[CHANNELS]) else $error("sync not presented");
  chk_sync_switch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ext_sync_disable_switch_in && $stable(status_q[CHANNELS]) |-> !sync_pulse) else $error("sync while disconnected");
  chk_detect_status: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    detect != '0 |=> (status_q & NB'($past(detect))) == NB'($past(detect))) else $error("detection not recorded");
  chk_watch_source: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (watch & ~$past(watch)) == ($past(detect) & ~$past(watch))) else $error("watch set without detection");
  chk_irq_level: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ce_in && detect[0] && mask_q[0] |=> irq_out && watch[0]) else $error("unmasked detection gave no interrupt");

  // Software clears status with no new event
  sequence s_status_clear;
    wr_status && events == '0;
  endsequence

  // A channel clear select is live
  sequence s_select_live;
    ce_in && channel_clear_select_ff_q != '0;
  endsequence

  // Some watch bit falls
  sequence s_watch_fall;
    (~watch & $past(watch)) != '0;
  endsequence

  // Control write lands as written
  chk_ctrl_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_ctrl |=> ctrl_q == $past(hwdata_in[CTRL_WIDTH-1:0])) else $error("control write lost");
  // Mask write lands as written
  chk_mask_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_mask |=> mask_q == $past(hwdata_in[NB-1:0])) else $error("mask write lost");
  // Written ones clear their status bits
  chk_status_w1c: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_status_clear |=> (status_q & $past(hwdata_in[NB-1:0])) == '0) else $error("status bit not cleared");
  // Status bits stay set until written
  chk_status_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !wr_status |=> (status_q & $past(status_q)) == $past(status_q)) else $error("status bit lost");
  // Status bits rise only from events
  chk_status_source: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (status_q & ~$past(status_q)) == ($past(events) & ~$past(status_q))) else $error("status set without event");
  // Clear select lasts one cycle per write
  chk_select_one_cycle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ce_in && !wr_chan_clear |=> channel_clear_select_ff_q == '0) else $error("clear select stuck");
  // A live select drops its watch bits
  chk_select_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_select_live |=> (watch & $past(channel_clear_select_ff_q) & ~$past(detect)) == '0) else $error("clear lost");
  // External lockout stops watch setting
  chk_ext_blocks_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    external_irq_lockout_ff |=> (watch & ~$past(watch)) == '0) else $error("watch set under lockout");
  // Watch bits fall only after a clear
  chk_watch_fall: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_watch_fall |-> $past(clear_all_q) || $past(channel_clear_select_ff_q) != '0) else $error("watch fell alone");
  // Read data stands between read address phases
  chk_read_stands: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(addr_phase && !hwrite_in) |=> $stable(hrdata_out)) else $error("read data changed");

endmodule // ext_irq_monitor

//--- test/ext_peer.sv
// Partner model of the outside device raising channel requests and sync
`timescale 1ns/1ps
module ext_peer #(
  parameter int unsigned CHANNELS = 4
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Commands from the bench
  input wire logic [CHANNELS-1:0] want_req_in,
  input wire logic want_sync_in,
  input wire logic slow_in,
  // Lines into the block
  output logic [CHANNELS-1:0] request_out,
  output logic sync_out
);
  logic [CHANNELS:0] stage_q;
  // ****************************************
  // Line drivers, prompt or one cycle late
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_q <= '0;
      request_out <= '0;
      sync_out <= 1'b0;
    end else begin
      stage_q <= {want_sync_in, want_req_in};
      {sync_out, request_out} <= slow_in ? stage_q : {want_sync_in, want_req_in};
    end
  end
endmodule // ext_peer

//--- test/ext_irq_monitor_test.sv
// Self-checking bench for the external interrupt monitor block
`timescale 1ns/1ps
module ext_irq_monitor_test;
  import ext_irq_pkg::*;
  localparam int unsigned CH = 4;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [1:0] hresp;
  logic [31:0] hrdata;
  logic [CH-1:0] want_req = '0;
  logic [CH-1:0] req;
  logic [CH-1:0] watch;
  logic want_sync = 1'b0;
  logic slow = 1'b0;
  logic sync;
  logic sw = 1'b0;
  logic irq;
  logic [CH:0] svc;
  int err_total = 0;
  int num_checks = 0;
  integer seed = 32'hd0d364b9;
  int exp_watch, exp_status, exp_mask, r, lock;

  // Clock of 50 ns
  always #25 core_clk_in = ~core_clk_in;

  ext_irq_monitor #(.CHANNELS(CH)) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
    .ext_irq_request_in(req), .ext_sync_in(sync), .ext_sync_disable_switch_in(sw),
    .ext_irq_watch_ff_out(watch), .service_req_out(svc), .irq_out(irq));

  ext_peer #(.CHANNELS(CH)) peer_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .want_req_in(want_req),
    .want_sync_in(want_sync), .slow_in(slow), .request_out(req), .sync_out(sync));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge core_clk_in);
    // No wait states while enabled
    check("hready", 32'(hreadyout), 32'h1);
    while (hreadyout !== 1'b1) @(posedge core_clk_in);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge core_clk_in);
    while (hreadyout !== 1'b1) @(posedge core_clk_in);
    q = hrdata;
    check("hresp", 32'(hresp), 32'(HRESP_OKAY));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rcheck(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(n, q, e);
  endtask

  // Peer commands, with random lag
  task automatic drive(input logic [CH-1:0] rq, input logic s);
    @(posedge core_clk_in);
    want_req <= rq;
    want_sync <= s;
    slow <= 1'($random(seed));
    // Hold a cycle so a change of lag cannot swallow a short level
    @(posedge core_clk_in);
  endtask

  // Let events land, then compare with the model
  task automatic look;
    repeat (4) @(posedge core_clk_in);
    #1;
    check("watch", 32'(watch), 32'(exp_watch));
    check("service", 32'(svc), 32'(exp_status));
    check("irq", 32'(irq), 32'((exp_status & exp_mask) != 0));
  endtask

  task automatic clear_all;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_STATUS, 32'h1f);
    exp_watch = 0;
    exp_status = 0;
    look;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_watch = 0;
    exp_status = 0;
    exp_mask = 0;
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // Reset values, unmapped space, mask read back
    rcheck("ctrl", OFS_CTRL, 32'(CTRL_RESET));
    rcheck("mask", OFS_MASK, MASK_RESET);
    rcheck("status", OFS_STATUS, STATUS_RESET);
    rcheck("unmapped", 8'h18, 32'h0);
    wr(8'h18, 32'hffffffff);
    look;
    exp_mask = $random(seed) & 32'h1f;
    wr(OFS_MASK, exp_mask);
    rcheck("mask", OFS_MASK, exp_mask);
    // One channel request sets watch and status
    r = $unsigned($random(seed)) % CH;
    drive(CH'(1 << r), 1'b0);
    exp_watch = 1 << r;
    exp_status = 1 << r;
    look;
    rcheck("request", OFS_REQUEST, 32'(1 << r));
    rcheck("watch reg", OFS_WATCH, 32'(1 << r));
    // A second request while watched is ignored
    drive('0, 1'b0);
    wr(OFS_STATUS, 32'(1 << r));
    exp_status = 0;
    drive(CH'(1 << r), 1'b0);
    look;
    drive('0, 1'b0);
    // Watch holds while global lockout is set, clears when it drops
    wr(OFS_CTRL, 32'h1);
    look;
    rcheck("ctrl", OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    exp_watch = 0;
    look;
    // Per-channel clear leaves the others set
    drive(4'h6, 1'b0);
    exp_watch = 6;
    exp_status = 6;
    look;
    drive('0, 1'b0);
    wr(OFS_CHAN_CLEAR, 32'h2);
    exp_watch = 4;
    look;
    rcheck("chan clear", OFS_CHAN_CLEAR, 32'h0);
    clear_all;
    // External lockout blocks detection, release lets it through
    wr(OFS_CTRL, 32'h2);
    drive(4'h9, 1'b0);
    look;
    wr(OFS_CTRL, 32'h0);
    exp_watch = 9;
    exp_status = 9;
    look;
    drive('0, 1'b0);
    clear_all;
    // Sync one-shot, once per rising edge
    drive('0, 1'b1);
    exp_status = 16;
    look;
    wr(OFS_STATUS, 32'h10);
    exp_status = 0;
    look;
    drive('0, 1'b0);
    drive('0, 1'b1);
    exp_status = 16;
    look;
    // Interrupt raised, masked, cleared
    exp_mask = 16;
    wr(OFS_MASK, exp_mask);
    look;
    exp_mask = 0;
    wr(OFS_MASK, exp_mask);
    look;
    exp_mask = 16;
    wr(OFS_MASK, exp_mask);
    wr(OFS_STATUS, 32'h10);
    exp_status = 0;
    look;
    drive('0, 1'b0);
    // Disconnect switch suppresses sync
    sw <= 1'b1;
    drive('0, 1'b1);
    look;
    drive('0, 1'b0);
    sw <= 1'b0;
    // Random request patterns under random external lockout
    repeat (8) begin
      r = $random(seed) & 32'hf;
      lock = $random(seed) & 32'h1;
      exp_mask = $random(seed) & 32'h1f;
      wr(OFS_MASK, exp_mask);
      wr(OFS_CTRL, 32'(lock << 1));
      drive(CH'(r), 1'b0);
      exp_watch = lock ? 0 : r;
      exp_status = exp_watch;
      look;
      drive('0, 1'b0);
      clear_all;
    end
    finish_test;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_total++;
    finish_test;
  end
endmodule // ext_irq_monitor_test
